// *** logic/card_buf_pkg.sv ***
/*
 * Shared constants for the card read buffer with clock gating.
 * Assumes the buffer drains on the system clock and the card side runs on the feedback clock.
 */
package card_buf_pkg;
	localparam int PORTION_BYTES = 512;
	localparam int DATA_W        = 8;
	localparam int FIFO_DEPTH    = 16;
	localparam int CRC_W         = 16;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [15:0] CRC_INIT  = 16'h0000;
	localparam logic [1:0]  WIDTH_1   = 2'h0;
	localparam logic [1:0]  WIDTH_4   = 2'h1;
	localparam logic [1:0]  WIDTH_8   = 2'h2;
	localparam logic [9:0]  PORTION_LAST = 10'h1FF;
endpackage

// *** logic/sync_fifo.sv ***
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an active low asynchronous reset.
 */
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** logic/card_read_buffer_clock_gate.sv ***
/*
 * Multiple-block card read path: link capture on the feedback clock, a small
 * staging FIFO, a two-portion read buffer, and card clock gating.
 * Assumes the card drives data on the feedback clock and the processor pops bytes.
 */
// What this block does
// [R1] Received bytes go into two 512-byte portions that the processor drains.
// [R2] Multiple-block reads run continuously; processor polls or takes the full pulse.
// [R3] With no free portion the card clock stops so the card stops sending.
// [R4] While both portions are full, data enable stays low and clock stays off.
// [R5] Clock restarts only after the processor has fully emptied one portion.
// [R6] Card clock and data enable come from the same internal clock edge.
// [R7] Data enable is raised before the first returned clock edge on restart.
// [R8] Bus width is one, four or eight bits, chosen by the width input.
// [R9] Each block's CRC is checked and a mismatch raises the CRC error flag.
// [R10] A pulse and level flag tell the processor when a portion is full.
`timescale 1ns/1ps
module card_read_buffer_clock_gate (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       fb_clock,
	input  wire logic       read_active,
	input  wire logic [1:0] bus_width,
	input  wire logic [7:0] card_dat,
	input  wire logic       crc_in,
	input  wire logic       crc_last,
	input  wire logic       proc_pop,
	output logic [7:0]      proc_data,
	output logic            proc_valid,
	output logic            portion_full,
	output logic            portion_full_pulse,
	output logic            crc_error,
	output logic            card_clk_en,
	output logic            data_en
);
	////////////////////////////////////////////////////////////////////////////////
	// Link side on the feedback clock.
	logic       run_s1_q;
	logic       run_s2_q;
	logic [7:0] shift_q;
	logic [3:0] nib_q;
	logic       lbyte_valid_q;
	logic [7:0] lbyte_q;
	logic [15:0] crc_q;
	logic        crc_bad_tgl_q;
	logic [2:0]  bitcnt_q;
	logic [1:0]  width_s1_q;
	logic [1:0]  width_s2_q;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? card_buf_pkg::CRC_POLY : 16'h0000);
	endfunction

	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			run_s1_q <= 1'b0;
			run_s2_q <= 1'b0;
		end else begin
			run_s1_q <= data_en;
			run_s2_q <= run_s1_q;
		end
	end

	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			width_s1_q <= card_buf_pkg::WIDTH_8;
			width_s2_q <= card_buf_pkg::WIDTH_8;
		end else begin
			width_s1_q <= bus_width;
			width_s2_q <= width_s1_q;
		end
	end

	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_q       <= 8'h00;
			nib_q         <= 4'h0;
			bitcnt_q      <= 3'h0;
			lbyte_valid_q <= 1'b0;
			lbyte_q       <= 8'h00;
		end else begin
			lbyte_valid_q <= 1'b0;
			if (run_s2_q) begin
				unique case (width_s2_q) // see [R8]
					card_buf_pkg::WIDTH_1: begin
						shift_q  <= {shift_q[6:0], card_dat[0]};
						bitcnt_q <= bitcnt_q + 3'h1;
						if (bitcnt_q == 3'h7) begin
							lbyte_q       <= {shift_q[6:0], card_dat[0]};
							lbyte_valid_q <= 1'b1;
						end
					end
					card_buf_pkg::WIDTH_4: begin
						bitcnt_q <= {2'h0, ~bitcnt_q[0]};
						nib_q    <= card_dat[3:0];
						if (bitcnt_q[0]) begin
							lbyte_q       <= {nib_q, card_dat[3:0]};
							lbyte_valid_q <= 1'b1;
						end
					end
					default: begin
						lbyte_q       <= card_dat;
						lbyte_valid_q <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			crc_q         <= card_buf_pkg::CRC_INIT;
			crc_bad_tgl_q <= 1'b0;
		end else if (run_s2_q) begin
			if (crc_last) begin
				crc_q <= card_buf_pkg::CRC_INIT;
				if (crc_step(crc_q, crc_in) != 16'h0000) begin
					crc_bad_tgl_q <= ~crc_bad_tgl_q; // see [R9]
				end
			end else begin
				crc_q <= crc_step(crc_q, crc_in);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte crossing: four held slots and a gray-coded write pointer.
	// A slot is rewritten only four bytes later, long after the clock side has read it.
	logic [7:0] slot_q [4];
	logic [1:0] wgray_q;
	logic [1:0] g_s1_q;
	logic [1:0] g_s2_q;
	logic [1:0] rgray_q;
	logic       x_valid;
	logic [7:0] x_data;
	logic       c_s1_q;
	logic       c_s2_q;
	logic       c_s3_q;

	function automatic logic [1:0] gray_next(input logic [1:0] g);
		gray_next = {g[0], ~g[1]};
	endfunction

	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			wgray_q <= 2'h0;
		end else if (lbyte_valid_q) begin
			wgray_q <= gray_next(wgray_q);
		end
	end

	always_ff @(posedge fb_clock) begin
		if (lbyte_valid_q) begin
			slot_q[wgray_q] <= lbyte_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			g_s1_q <= 2'h0;
			g_s2_q <= 2'h0;
			c_s1_q <= 1'b0;
			c_s2_q <= 1'b0;
			c_s3_q <= 1'b0;
		end else begin
			g_s1_q <= wgray_q;
			g_s2_q <= g_s1_q;
			c_s1_q <= crc_bad_tgl_q;
			c_s2_q <= c_s1_q;
			c_s3_q <= c_s2_q;
		end
	end

	assign x_valid = (g_s2_q != rgray_q);
	assign x_data  = slot_q[rgray_q];

	////////////////////////////////////////////////////////////////////////////////
	// Staging FIFO and two-portion buffer.
	logic       f_ready;
	logic [7:0] f_data;
	logic       f_valid;
	logic       f_take;
	logic [7:0] buf_q [2*card_buf_pkg::PORTION_BYTES];
	logic       wsel_q;
	logic [9:0] widx_q;
	logic       rsel_q;
	logic [9:0] ridx_q;
	logic [1:0] full_q;

	sync_fifo #(
		.WIDTH (card_buf_pkg::DATA_W),
		.DEPTH (card_buf_pkg::FIFO_DEPTH)
	) sync_fifo_i (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_data   (x_data),
		.in_valid  (x_valid),
		.in_ready  (f_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (!full_q[wsel_q])
	);

	assign f_take = f_valid && !full_q[wsel_q];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rgray_q <= 2'h0;
		end else if (x_valid && f_ready) begin
			rgray_q <= gray_next(rgray_q); // see [R1]
		end
	end

	always_ff @(posedge clock) begin
		if (f_take) begin
			buf_q[{wsel_q, widx_q[8:0]}] <= f_data; // see [R1]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wsel_q             <= 1'b0;
			widx_q             <= 10'h000;
			rsel_q             <= 1'b0;
			ridx_q             <= 10'h000;
			full_q             <= 2'h0;
			portion_full_pulse <= 1'b0;
			proc_valid         <= 1'b0;
			proc_data          <= 8'h00;
		end else begin
			portion_full_pulse <= 1'b0;
			if (f_take) begin
				if (widx_q == card_buf_pkg::PORTION_LAST) begin
					widx_q             <= 10'h000;
					wsel_q             <= ~wsel_q;
					full_q[wsel_q]     <= 1'b1;
					portion_full_pulse <= 1'b1; // see [R10]
				end else begin
					widx_q <= widx_q + 10'h001;
				end
			end
			proc_valid <= full_q[rsel_q];
			proc_data  <= buf_q[{rsel_q, ridx_q[8:0]}];
			if (proc_pop && proc_valid) begin // see [R2]
				proc_valid <= 1'b0;
				if (ridx_q == card_buf_pkg::PORTION_LAST) begin
					ridx_q         <= 10'h000;
					rsel_q         <= ~rsel_q;
					full_q[rsel_q] <= 1'b0; // see [R5]
				end else begin
					ridx_q <= ridx_q + 10'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Card clock gate and data enable, both from one flop edge.
	logic stall;
	assign stall = (full_q == 2'h3) || !f_ready || (f_valid && full_q[wsel_q]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			card_clk_en  <= 1'b0;
			data_en      <= 1'b0;
			portion_full <= 1'b0;
			crc_error    <= 1'b0;
		end else begin
			card_clk_en  <= read_active && !stall; // see [R3] see [R4] see [R6]
			data_en      <= read_active && !stall; // see [R7]
			portion_full <= full_q[rsel_q];
			if (c_s2_q != c_s3_q) begin
				crc_error <= 1'b1;
			end else if (!read_active) begin
				crc_error <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	AST_STALL_OFF: assert property (@(posedge clock) disable iff (!rst_n) // see [R4]
		(full_q == 2'h3) |=> !card_clk_en && !data_en)
		else $error("clock running with both portions full");
	AST_NO_FREE: assert property (@(posedge clock) disable iff (!rst_n) // see [R3]
		!f_ready |=> !card_clk_en)
		else $error("clock running without space");
	AST_SAME_EDGE: assert property (@(posedge clock) disable iff (!rst_n) // see [R6]
		card_clk_en == data_en)
		else $error("clock and data enable diverge");
	AST_RESTART: assert property (@(posedge clock) disable iff (!rst_n) // see [R5]
		$rose(card_clk_en) |-> $past(read_active) && $past(full_q) != 2'h3)
		else $error("restart with no emptied portion");
	AST_EN_FIRST: assert property (@(posedge clock) disable iff (!rst_n) // see [R7]
		$rose(card_clk_en) |-> data_en)
		else $error("data enable late on restart");
	AST_FULL_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // see [R10]
		portion_full_pulse |-> ##[1:2] portion_full)
		else $error("full portion not flagged");
	AST_WIDX: assert property (@(posedge clock) disable iff (!rst_n) // see [R1]
		widx_q <= card_buf_pkg::PORTION_LAST)
		else $error("write index past portion");
	AST_CRC: assert property (@(posedge clock) disable iff (!rst_n) // see [R9]
		(c_s2_q != c_s3_q) |=> crc_error)
		else $error("crc failure not reported");
	AST_POP: assert property (@(posedge clock) disable iff (!rst_n) // see [R2]
		(proc_pop && proc_valid) |=> !proc_valid)
		else $error("pop not acknowledged");
	AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // see [R2]
		(proc_valid && !proc_pop) |=> proc_valid && $stable(proc_data))
		else $error("byte withdrawn before it was taken");
	AST_PULSE_ONE: assert property (@(posedge clock) disable iff (!rst_n) // see [R10]
		portion_full_pulse |=> !portion_full_pulse)
		else $error("full pulse longer than one cycle");
	AST_RIDX: assert property (@(posedge clock) disable iff (!rst_n) // see [R1]
		ridx_q <= card_buf_pkg::PORTION_LAST)
		else $error("read index past portion");
	AST_CRC_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // see [R9]
		(!read_active && c_s2_q == c_s3_q) |=> !crc_error)
		else $error("crc error held after the read ended");
	AST_FIFO_ROOM: assert property (@(posedge clock) disable iff (!rst_n) // see [R3]
		f_ready)
		else $error("staging fifo filled before the clock stopped");
	AST_PORTION_FREE: assert property (@(posedge clock) disable iff (!rst_n) // see [R5]
		(proc_pop && proc_valid && ridx_q == card_buf_pkg::PORTION_LAST) |=> !full_q[~rsel_q])
		else $error("drained portion still marked full");
	AST_GRAY: assert property (@(posedge fb_clock) disable iff (!rst_n) // see [R1]
		wgray_q == $past(wgray_q) || wgray_q == gray_next($past(wgray_q)))
		else $error("write pointer moved by more than one step");
	AST_LINK_STOP: assert property (@(posedge fb_clock) disable iff (!rst_n) // see [R3]
		!run_s2_q |=> !lbyte_valid_q)
		else $error("byte captured while the link was stopped");

	COV_FULL: cover property (@(posedge clock) disable iff (!rst_n) full_q == 2'h3);
	COV_WIDTH_1: cover property (@(posedge fb_clock) disable iff (!rst_n)
		run_s2_q && width_s2_q == card_buf_pkg::WIDTH_1);
	COV_WIDTH_4: cover property (@(posedge fb_clock) disable iff (!rst_n)
		run_s2_q && width_s2_q == card_buf_pkg::WIDTH_4);
	COV_RESTART: cover property (@(posedge clock) disable iff (!rst_n)
		(full_q == 2'h3) ##[1:1000] $rose(card_clk_en));
	COV_CRC: cover property (@(posedge clock) disable iff (!rst_n) $rose(crc_error));
endmodule

// *** bench/card_model.sv ***
/* Card side model: streams an incrementing byte pattern at the chosen bus width.
   Assumes a free running feedback clock and data enable from the host side. */
`timescale 1ns/1ps
module card_model (
	input  wire logic       fb_clock,
	input  wire logic       rst_n,
	input  wire logic       data_en,
	input  wire logic [1:0] bus_width,
	input  wire logic [7:0] base,
	output logic [7:0]      card_dat,
	output logic [15:0]     sent
);
	logic       s1_q;
	logic       s2_q;
	logic [2:0] sub_q;
	logic [2:0] last;
	logic [7:0] val;
	logic       bit_v;
	assign last  = (bus_width == 2'h0) ? 3'h7 : (bus_width == 2'h1) ? 3'h1 : 3'h0;
	assign val   = base + sent[7:0];
	assign bit_v = val[3'h7 - sub_q];
	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'h0;
			s2_q <= 1'h0;
		end else begin
			s1_q <= data_en;
			s2_q <= s1_q;
		end
	end
	// The card moves on only while its clock is let through.
	always_ff @(posedge fb_clock or negedge rst_n) begin
		if (!rst_n) begin
			sub_q <= 3'h0;
			sent  <= 16'h0000;
		end else if (s2_q) begin
			sub_q <= (sub_q == last) ? 3'h0 : sub_q + 3'h1;
			if (sub_q == last)
				sent <= sent + 16'h0001;
		end
	end
	// Unused lines carry the inverse of the live bits.
	always_comb begin
		case (last)
			3'h7: card_dat = {{7{~bit_v}}, bit_v};
			3'h1: card_dat = (sub_q == 3'h0) ? {~val[7:4], val[7:4]} : {~val[3:0], val[3:0]};
			default: card_dat = val;
		endcase
	end
endmodule

// *** bench/card_read_buffer_clock_gate_test.sv ***
/* Bench for the card read buffer: one row per bus_width code (2'h3 runs as eight bits), then stall and CRC cases.
   Assumes card_model and the design files are compiled first. */
`timescale 1ns/1ps
module card_read_buffer_clock_gate_test;
	typedef struct packed {logic [1:0] w; logic [7:0] base; logic [7:0] first;} row_t;
	logic        clock, rst_n, fb_clock, read_active, crc_in, crc_last, proc_pop;
	logic [1:0]  bus_width;
	logic [7:0]  base, card_dat, proc_data;
	logic        proc_valid, portion_full, portion_full_pulse, crc_error, card_clk_en, data_en;
	logic [15:0] sent, hold;
	int          mismatches, check_count, pulses, n, i, r;
	row_t        rows [4] = '{'{2'h0, 8'h11, 8'h11}, '{2'h1, 8'hA5, 8'hA5},
	                          '{2'h2, 8'hFE, 8'hFE}, '{2'h3, 8'h00, 8'h00}};
	card_read_buffer_clock_gate card_read_buffer_clock_gate_i (.clock(clock), .rst_n(rst_n),
		.fb_clock(fb_clock), .read_active(read_active), .bus_width(bus_width),
		.card_dat(card_dat), .crc_in(crc_in), .crc_last(crc_last), .proc_pop(proc_pop),
		.proc_data(proc_data), .proc_valid(proc_valid), .portion_full(portion_full),
		.portion_full_pulse(portion_full_pulse), .crc_error(crc_error),
		.card_clk_en(card_clk_en), .data_en(data_en));
	card_model card_model_i (.fb_clock(fb_clock), .rst_n(rst_n), .data_en(data_en),
		.bus_width(bus_width), .base(base), .card_dat(card_dat), .sent(sent));
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		fb_clock = 1'h0;
		#1.3;
		forever #6 fb_clock = ~fb_clock;
	end
	always @(posedge clock) begin
		if (portion_full_pulse === 1'h1)
			pulses++;
	end
	////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic pick(input int k);
		return (k == 0) ? proc_valid : (k == 1) ? card_clk_en : crc_error;
	endfunction
	task wait_for(input int k, input logic lvl, input int bound);
		n = 0;
		while (pick(k) !== lvl && n < bound) begin
			@(negedge clock);
			n++;
		end
		if (n >= bound) begin
			mismatches++;
			complete_run();
		end
	endtask
	task pop_check(input logic [7:0] exp);
		wait_for(0, 1'h1, 30000);
		check(proc_data, exp);
		proc_pop = 1'h1;
		@(negedge clock);
		proc_pop = 1'h0;
		@(negedge clock);
	endtask
	task do_reset(input logic [1:0] w, input logic [7:0] b);
		rst_n = 1'h0;
		read_active = 1'h0;
		bus_width = w;
		base = b;
		repeat (10) @(negedge clock);
		check({proc_valid, portion_full, portion_full_pulse, crc_error, card_clk_en, data_en}, 16'h0000);
		rst_n = 1'h1;
		pulses = 0;
		@(negedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, read_active, crc_in, crc_last, proc_pop} = 5'h00;
		bus_width = 2'h2;
		base = 8'h00;
		mismatches = 0;
		check_count = 0;
		for (r = 0; r < 4; r++) begin
			do_reset(rows[r].w, rows[r].base);
			read_active = 1'h1;
			wait_for(0, 1'h1, 30000);
			check(portion_full, 16'h0001);
			for (i = 0; i < 512; i++)
				pop_check(rows[r].first + i[7:0]);
		end
		do_reset(2'h2, 8'h30);
		read_active = 1'h1;
		wait_for(1, 1'h1, 200);
		wait_for(1, 1'h0, 4000);
		check(data_en, 16'h0000);
		check(pulses, 16'h0002);
		repeat (4) @(negedge fb_clock);
		hold = sent;
		repeat (200) @(negedge clock);
		check({card_clk_en, data_en}, 16'h0000);
		check(sent, hold);
		check(sent >= 16'h0400, 16'h0001);
		for (i = 0; i < 511; i++)
			pop_check(8'h30 + i[7:0]);
		check(card_clk_en, 16'h0000);
		pop_check(8'h2F);
		wait_for(1, 1'h1, 200);
		check(data_en, card_clk_en);
		for (i = 512; i < 1536; i++)
			pop_check(8'h30 + i[7:0]);
		@(negedge fb_clock);
		crc_last = 1'h1;
		@(negedge fb_clock);
		crc_last = 1'h0;
		repeat (20) @(negedge clock);
		check(crc_error, 16'h0000);
		for (i = 0; i < 16; i++) begin
			@(negedge fb_clock);
			crc_in = 1'h1;
			crc_last = (i == 15);
		end
		@(negedge fb_clock);
		crc_in = 1'h0;
		crc_last = 1'h0;
		wait_for(2, 1'h1, 100);
		read_active = 1'h0;
		repeat (5) @(negedge clock);
		check(crc_error, 16'h0000);
		complete_run();
	end
endmodule
